// ==== mss_client.sv ====
// client model: takes every received byte and counts frames
`timescale 1ns/100ps
module mss_client (
  input wire logic clk,
  input wire logic resetn,
  input wire logic tvalid,
  input wire logic tlast,
  input wire logic tuser,
  output int n_bytes,
  output int n_frames,
  output int n_bad
);
  // no ready line exists, so every valid cycle is a byte taken
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      n_bytes <= 0;
      n_frames <= 0;
      n_bad <= 0;
    end else if (tvalid) begin
      n_bytes <= n_bytes + 1;
      n_frames <= n_frames + int'(tlast);
      n_bad <= n_bad + int'(tlast & tuser);
    end
  end
endmodule : mss_client

// ==== mss_pkg.sv ====
// package: constants and carriers for the mac statistics and receive stream block
package mss_pkg;

  // ------------------------------------------------------------------
  // transmit statistics word layout
  // ------------------------------------------------------------------
  localparam int MSS_TXS_W = 32;
  localparam int MSS_TXS_RSV_HI = 29;
  localparam int MSS_TXS_ATT_HI = 28;
  localparam int MSS_TXS_ATT_LO = 25;
  localparam int MSS_TXS_RSV_LO = 24;
  localparam int MSS_TXS_EXCOLL = 23;
  localparam int MSS_TXS_LATE = 22;
  localparam int MSS_TXS_OVERLONG = 21;
  localparam int MSS_TXS_DEFER = 20;
  localparam int MSS_TXS_TAGGED = 19;
  localparam int MSS_TXS_LEN_HI = 18;
  localparam int MSS_TXS_LEN_LO = 5;
  localparam int MSS_TXS_CTRL = 4;
  localparam int MSS_TXS_UNDER = 3;
  localparam int MSS_TXS_MCAST = 2;
  localparam int MSS_TXS_BCAST = 1;
  localparam int MSS_TXS_OK = 0;

  // ------------------------------------------------------------------
  // frame constants
  // ------------------------------------------------------------------
  localparam logic [15:0] MSS_LEN_SAT = 16'h3FF0;
  localparam logic [15:0] MSS_TYPE_CTRL = 16'h8808;
  localparam logic [15:0] MSS_TYPE_VLAN = 16'h8100;
  localparam logic [47:0] MSS_DA_BCAST = 48'hFFFF_FFFF_FFFF;
  localparam int MSS_DA_GROUP_BIT = 0;
  localparam logic [4:0] MSS_MAX_TRIES = 5'h10;
  localparam logic [4:0] MSS_ONE_TRY = 5'h01;
  localparam int MSS_RXS_W = 28;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam logic [11:0] MSS_REG_CTRL = 12'h000;
  localparam logic [11:0] MSS_REG_TXSTAT = 12'h004;
  localparam logic [11:0] MSS_REG_RXSTAT = 12'h008;
  localparam int MSS_CTRL_VLAN_EN = 0;
  localparam logic MSS_CTRL_RESET = 1'b0;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic late_coll;
    logic defer_long;
    logic deferred;
    logic underrun;
    logic [15:0] ftype;
    logic [47:0] da;
    logic [15:0] len;
  } mss_tx_outcome_t;

  typedef enum logic {
    MSS_TX_IDLE = 1'b0,
    MSS_TX_BUSY = 1'b1
  } mss_tx_st_t;

endpackage : mss_pkg

// ==== mss_top.sv ====
// mac statistics packing, receive stream delivery and apb status registers
//
// Function
// R01: attempts minus one in bits 28:25
// R02: bit 23 when all 16 attempts collided
// R03: bit 22 on late collision
// R04: bit 21 when deferral exceeded maximum
// R05: bit 20 whenever frame was deferred
// R06: bit 19 tagged frame, only if enabled
// R07: length in 18:5, saturating at 16368
// R08: bit 4 for control type 88-08
// R09: bit 3 on underrun
// R10: bit 2 for multicast destination
// R11: bit 1 for broadcast destination
// R12: bit 0 only when error free
// R13: received bytes on 8-bit data with valid
// R14: last flag with final frame byte
// R15: user flag at end on errored frame
// R16: one pass flag per frame filter
// R17: 28-bit receive statistics word
// R18: statistics valid pulses at frame end
// R19: all stream signals active high
// R20: transmit statistics valid pulses at end
// R21: reserved bits 29 and 24 zero
// R22: client takes every byte, no backpressure
// R23: all outputs synchronous to the clock
`timescale 1ns/100ps
module mss_top
  import mss_pkg::*;
#(
  parameter int FILTERS = 4
) (
  input wire logic CLK,
  input wire logic RESETN,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // transmit outcome from the mac engine
  input wire logic TX_START,
  input wire logic TX_ATTEMPT,
  input wire logic TX_COLLISION,
  input wire logic TX_END,
  input wire mss_tx_outcome_t TX_OUTCOME,
  output logic [MSS_TXS_W-1:0] TX_STATS,
  output logic TX_STATS_VALID,
  // receive side from the mac engine
  input wire logic RX_IN_VALID,
  input wire logic [7:0] RX_IN_DATA,
  input wire logic RX_IN_LAST,
  input wire logic RX_IN_ERR,
  input wire logic [FILTERS-1:0] RX_IN_FILT,
  input wire logic [MSS_RXS_W-1:0] RX_IN_STATS,
  output logic [7:0] RX_TDATA,
  output logic RX_TVALID,
  output logic RX_TLAST,
  output logic RX_TUSER,
  output logic [FILTERS-1:0] RX_FILTER_TUSER,
  output logic [MSS_RXS_W-1:0] RX_STATS,
  output logic RX_STATS_VALID
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    mss_tx_st_t tx_st;
    logic [4:0] tries;
    logic [4:0] colls;
    logic vlan_en;
    logic [MSS_TXS_W-1:0] tx_stats;
    logic tx_val;
    logic [7:0] rx_data;
    logic rx_valid;
    logic rx_last;
    logic rx_user;
    logic [FILTERS-1:0] rx_filt;
    logic [MSS_RXS_W-1:0] rx_stats;
    logic rx_sval;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } mss_state_t;

  mss_state_t q;
  mss_state_t next_q;

  logic [4:0] tries_now;
  logic [4:0] colls_now;
  logic [15:0] len_sat;
  logic [MSS_TXS_W-1:0] word;
  logic setup;
  logic wr_done;
  logic hit;

  // ------------------------------------------------------------------
  // transmit word assembly
  // ------------------------------------------------------------------
  always_comb begin
    // an attempt or collision pulsing with the end still counts
    tries_now = q.tries + {4'h0, TX_ATTEMPT};
    colls_now = q.colls + {4'h0, TX_COLLISION};
    // a seventeenth attempt must not wrap the field back to zero
    if (tries_now > MSS_MAX_TRIES) begin
      tries_now = MSS_MAX_TRIES; // [R01]
    end
    len_sat = (TX_OUTCOME.len > MSS_LEN_SAT) ? MSS_LEN_SAT : TX_OUTCOME.len; // [R07]
    word = '0; // [R21]
    word[MSS_TXS_ATT_HI:MSS_TXS_ATT_LO] = (tries_now == 5'h00) ? 4'h0 : 4'(tries_now - MSS_ONE_TRY); // [R01]
    word[MSS_TXS_EXCOLL] = (colls_now >= MSS_MAX_TRIES) && (tries_now >= MSS_MAX_TRIES); // [R02]
    word[MSS_TXS_LATE] = TX_OUTCOME.late_coll; // [R03]
    word[MSS_TXS_OVERLONG] = TX_OUTCOME.defer_long; // [R04]
    word[MSS_TXS_DEFER] = TX_OUTCOME.deferred | TX_OUTCOME.defer_long; // [R05]
    word[MSS_TXS_TAGGED] = q.vlan_en && (TX_OUTCOME.ftype == MSS_TYPE_VLAN); // [R06]
    word[MSS_TXS_LEN_HI:MSS_TXS_LEN_LO] = len_sat[13:0]; // [R07]
    word[MSS_TXS_CTRL] = (TX_OUTCOME.ftype == MSS_TYPE_CTRL); // [R08]
    word[MSS_TXS_UNDER] = TX_OUTCOME.underrun; // [R09]
    word[MSS_TXS_MCAST] = TX_OUTCOME.da[MSS_DA_GROUP_BIT]; // [R10]
    word[MSS_TXS_BCAST] = (TX_OUTCOME.da == MSS_DA_BCAST); // [R11]
    // deferral alone is not an error; the failure causes are
    word[MSS_TXS_OK] = !(word[MSS_TXS_EXCOLL] | word[MSS_TXS_LATE] |
                         word[MSS_TXS_OVERLONG] | word[MSS_TXS_UNDER]); // [R12]
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  assign setup = PSEL && !PENABLE;
  assign wr_done = PSEL && PENABLE && q.pready && PWRITE;
  assign hit = (PADDR == MSS_REG_CTRL) || (PADDR == MSS_REG_TXSTAT) ||
               (PADDR == MSS_REG_RXSTAT);

  always_comb begin
    next_q = q;
    next_q.tx_val = 1'b0;
    next_q.rx_sval = 1'b0;
    next_q.pready = 1'b0;
    next_q.pslverr = 1'b0;

    unique case (q.tx_st)
      MSS_TX_IDLE: begin
        if (TX_START && !TX_END) begin
          next_q.tx_st = MSS_TX_BUSY;
          next_q.tries = {4'h0, TX_ATTEMPT};
          next_q.colls = {4'h0, TX_COLLISION};
        end
      end
      MSS_TX_BUSY: begin
        if (TX_END) begin
          next_q.tx_st = MSS_TX_IDLE;
        end else begin
          next_q.tries = (tries_now > MSS_MAX_TRIES) ? MSS_MAX_TRIES : tries_now;
          next_q.colls = (colls_now > MSS_MAX_TRIES) ? MSS_MAX_TRIES : colls_now;
        end
      end
    endcase

    if (TX_END) begin
      next_q.tx_stats = word;
      next_q.tx_val = 1'b1; // [R20]
      next_q.tries = 5'h00;
      next_q.colls = 5'h00;
    end

    // receive bytes pass straight through; nothing can stall them [R22]
    next_q.rx_valid = RX_IN_VALID; // [R13] [R19]
    next_q.rx_last = RX_IN_VALID && RX_IN_LAST; // [R14]
    next_q.rx_user = RX_IN_VALID && RX_IN_LAST && RX_IN_ERR; // [R15]
    if (RX_IN_VALID) begin
      next_q.rx_data = RX_IN_DATA; // [R13]
      next_q.rx_filt = RX_IN_FILT; // [R16]
    end
    if (RX_IN_VALID && RX_IN_LAST) begin
      next_q.rx_stats = RX_IN_STATS; // [R17]
      next_q.rx_sval = 1'b1; // [R18]
    end

    // apb: answer in the first access cycle, zero wait states
    if (setup) begin
      next_q.pready = 1'b1;
      next_q.pslverr = !hit;
      next_q.prdata = '0;
      if (!PWRITE) begin
        if (PADDR == MSS_REG_CTRL) begin
          next_q.prdata[MSS_CTRL_VLAN_EN] = q.vlan_en;
        end else if (PADDR == MSS_REG_TXSTAT) begin
          next_q.prdata = q.tx_stats;
        end else if (PADDR == MSS_REG_RXSTAT) begin
          next_q.prdata = {{(32-MSS_RXS_W){1'b0}}, q.rx_stats};
        end
      end
    end
    if (wr_done && (PADDR == MSS_REG_CTRL)) begin
      next_q.vlan_en = PWDATA[MSS_CTRL_VLAN_EN]; // [R06]
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN) begin // [R23]
    if (!RESETN) begin
      q <= '{tx_st: MSS_TX_IDLE, vlan_en: MSS_CTRL_RESET, default: '0};
    end else begin
      q <= next_q;
    end
  end

  assign TX_STATS = q.tx_stats;
  assign TX_STATS_VALID = q.tx_val;
  assign RX_TDATA = q.rx_data;
  assign RX_TVALID = q.rx_valid;
  assign RX_TLAST = q.rx_last;
  assign RX_TUSER = q.rx_user;
  assign RX_FILTER_TUSER = q.rx_filt;
  assign RX_STATS = q.rx_stats;
  assign RX_STATS_VALID = q.rx_sval;
  assign PRDATA = q.prdata;
  assign PREADY = q.pready;
  assign PSLVERR = q.pslverr;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  sequence s_tx_end;
    TX_END;
  endsequence

  sequence s_word_out;
    TX_STATS_VALID ##1 !TX_STATS_VALID;
  endsequence

  property p_tx_valid;
    @(posedge CLK) disable iff (!RESETN)
    s_tx_end ##1 !TX_END |-> s_word_out;
  endproperty
  a_tx_valid: assert property (p_tx_valid) else $error("tx stats valid not one pulse"); // [R20]

  property p_reserved;
    @(posedge CLK) disable iff (!RESETN)
    TX_STATS[MSS_TXS_RSV_HI] == 1'b0 && TX_STATS[MSS_TXS_RSV_LO] == 1'b0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved tx stats bit set"); // [R21]

  property p_attempts;
    @(posedge CLK) disable iff (!RESETN)
    TX_END && (q.tries == 5'h03) && !TX_ATTEMPT |=>
      TX_STATS[MSS_TXS_ATT_HI:MSS_TXS_ATT_LO] == 4'h2;
  endproperty
  a_attempts: assert property (p_attempts) else $error("attempt count wrong"); // [R01]

  property p_len_sat;
    @(posedge CLK) disable iff (!RESETN)
    TX_END && (TX_OUTCOME.len > MSS_LEN_SAT) |=>
      TX_STATS[MSS_TXS_LEN_HI:MSS_TXS_LEN_LO] == 14'(MSS_LEN_SAT);
  endproperty
  a_len_sat: assert property (p_len_sat) else $error("length not saturated"); // [R07]

  property p_ctrl;
    @(posedge CLK) disable iff (!RESETN)
    s_tx_end |=> TX_STATS[MSS_TXS_CTRL] == ($past(TX_OUTCOME.ftype) == MSS_TYPE_CTRL);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control frame flag wrong"); // [R08]

  property p_vlan_off;
    @(posedge CLK) disable iff (!RESETN)
    TX_END && !q.vlan_en |=> !TX_STATS[MSS_TXS_TAGGED];
  endproperty
  a_vlan_off: assert property (p_vlan_off) else $error("tagged flag while disabled"); // [R06]

  property p_ok;
    @(posedge CLK) disable iff (!RESETN)
    TX_STATS_VALID && TX_STATS[MSS_TXS_OK] |->
      !TX_STATS[MSS_TXS_LATE] && !TX_STATS[MSS_TXS_UNDER] && !TX_STATS[MSS_TXS_EXCOLL];
  endproperty
  a_ok: assert property (p_ok) else $error("success with error flag"); // [R12]

  property p_bcast;
    @(posedge CLK) disable iff (!RESETN)
    TX_STATS_VALID && TX_STATS[MSS_TXS_BCAST] |-> TX_STATS[MSS_TXS_MCAST];
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast without group bit"); // [R11]

  property p_rx_byte;
    @(posedge CLK) disable iff (!RESETN)
    RX_IN_VALID |=> RX_TVALID && RX_TDATA == $past(RX_IN_DATA);
  endproperty
  a_rx_byte: assert property (p_rx_byte) else $error("rx byte not delivered"); // [R13]

  property p_rx_last;
    @(posedge CLK) disable iff (!RESETN)
    RX_IN_VALID && RX_IN_LAST ##1 !(RX_IN_VALID && RX_IN_LAST) |->
      RX_TLAST && RX_STATS_VALID ##1 !RX_STATS_VALID;
  endproperty
  a_rx_last: assert property (p_rx_last) else $error("frame end not marked"); // [R14] [R18]

  property p_rx_user;
    @(posedge CLK) disable iff (!RESETN)
    RX_TUSER |-> RX_TLAST && RX_TVALID;
  endproperty
  a_rx_user: assert property (p_rx_user) else $error("rx error flag off frame end"); // [R15]

  property p_apb;
    @(posedge CLK) disable iff (!RESETN)
    setup |=> PREADY ##1 !PREADY;
  endproperty
  a_apb: assert property (p_apb) else $error("apb answer timing wrong");

  property p_excoll;
    @(posedge CLK) disable iff (!RESETN)
    TX_END && !TX_ATTEMPT && !TX_COLLISION && (q.tries == MSS_MAX_TRIES) &&
      (q.colls == MSS_MAX_TRIES) |=> TX_STATS[MSS_TXS_EXCOLL];
  endproperty
  a_excoll: assert property (p_excoll) else $error("excessive collision flag missing"); // [R02]

  property p_late;
    @(posedge CLK) disable iff (!RESETN)
    s_tx_end |=> TX_STATS[MSS_TXS_LATE] == $past(TX_OUTCOME.late_coll);
  endproperty
  a_late: assert property (p_late) else $error("late collision flag wrong"); // [R03]

  property p_overlong;
    @(posedge CLK) disable iff (!RESETN)
    s_tx_end |=> TX_STATS[MSS_TXS_OVERLONG] == $past(TX_OUTCOME.defer_long);
  endproperty
  a_overlong: assert property (p_overlong) else $error("overlong wait flag wrong"); // [R04]

  property p_defer;
    @(posedge CLK) disable iff (!RESETN)
    s_tx_end |=> TX_STATS[MSS_TXS_DEFER] == $past(TX_OUTCOME.deferred | TX_OUTCOME.defer_long);
  endproperty
  a_defer: assert property (p_defer) else $error("deferred flag wrong"); // [R05]

  property p_under;
    @(posedge CLK) disable iff (!RESETN)
    s_tx_end |=> TX_STATS[MSS_TXS_UNDER] == $past(TX_OUTCOME.underrun);
  endproperty
  a_under: assert property (p_under) else $error("underrun flag wrong"); // [R09]

  property p_mcast;
    @(posedge CLK) disable iff (!RESETN)
    s_tx_end |=> TX_STATS[MSS_TXS_MCAST] == $past(TX_OUTCOME.da[MSS_DA_GROUP_BIT]);
  endproperty
  a_mcast: assert property (p_mcast) else $error("multicast flag wrong"); // [R10]

  property p_ok_set;
    @(posedge CLK) disable iff (!RESETN)
    TX_STATS_VALID && !TX_STATS[MSS_TXS_LATE] && !TX_STATS[MSS_TXS_UNDER] &&
      !TX_STATS[MSS_TXS_EXCOLL] && !TX_STATS[MSS_TXS_OVERLONG] |-> TX_STATS[MSS_TXS_OK];
  endproperty
  a_ok_set: assert property (p_ok_set) else $error("clean frame not marked sent"); // [R12]

  property p_rx_idle;
    @(posedge CLK) disable iff (!RESETN)
    !RX_IN_VALID |=> !RX_TVALID && !RX_TLAST && !RX_TUSER && !RX_STATS_VALID;
  endproperty
  a_rx_idle: assert property (p_rx_idle) else $error("rx strobe without byte"); // [R13] [R19]

  property p_rx_err;
    @(posedge CLK) disable iff (!RESETN)
    RX_IN_VALID && RX_IN_LAST && RX_IN_ERR |=> RX_TUSER;
  endproperty
  a_rx_err: assert property (p_rx_err) else $error("errored frame not flagged"); // [R15]

  property p_rx_filt;
    @(posedge CLK) disable iff (!RESETN)
    RX_IN_VALID |=> RX_FILTER_TUSER == $past(RX_IN_FILT);
  endproperty
  a_rx_filt: assert property (p_rx_filt) else $error("filter pass flags wrong"); // [R16]

  property p_rx_stats;
    @(posedge CLK) disable iff (!RESETN)
    RX_IN_VALID && RX_IN_LAST |=> RX_STATS == $past(RX_IN_STATS);
  endproperty
  a_rx_stats: assert property (p_rx_stats) else $error("rx statistics word wrong"); // [R17]

endmodule : mss_top

// ==== testbench.sv ====
// self-checking bench for the statistics and receive stream block
`timescale 1ns/100ps
module testbench;
  import mss_pkg::*;
  logic CLK = 0, RESETN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [11:0] PADDR = '0;
  logic [31:0] PWDATA = '0, PRDATA, TX_STATS;
  logic PREADY, PSLVERR, TX_STATS_VALID, RX_TVALID, RX_TLAST, RX_TUSER, RX_STATS_VALID;
  logic TX_START = 0, TX_ATTEMPT = 0, TX_COLLISION = 0, TX_END = 0;
  mss_tx_outcome_t TX_OUTCOME = '0;
  logic RX_IN_VALID = 0, RX_IN_LAST = 0, RX_IN_ERR = 0;
  logic [7:0] RX_IN_DATA = '0, RX_TDATA;
  logic [3:0] RX_IN_FILT = '0, RX_FILTER_TUSER;
  logic [27:0] RX_IN_STATS = '0, RX_STATS, last_rx = '0;
  int n_fail = 0, checks = 0, cyc = 0, nb, nf, nbad, eb = 0, ef = 0, ebad = 0;
  logic ven = 0;
  logic [31:0] last_tx = '0;
  logic [33:0] e, apbq[$];
  logic [31:0] txq[$];
  logic [13:0] rxq[$];
  logic [27:0] rsq[$];
  always #25 CLK = ~CLK;
  mss_top #(.FILTERS(4)) uut (.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .TX_START(TX_START), .TX_ATTEMPT(TX_ATTEMPT),
    .TX_COLLISION(TX_COLLISION), .TX_END(TX_END), .TX_OUTCOME(TX_OUTCOME),
    .TX_STATS(TX_STATS), .TX_STATS_VALID(TX_STATS_VALID), .RX_IN_VALID(RX_IN_VALID),
    .RX_IN_DATA(RX_IN_DATA), .RX_IN_LAST(RX_IN_LAST), .RX_IN_ERR(RX_IN_ERR),
    .RX_IN_FILT(RX_IN_FILT), .RX_IN_STATS(RX_IN_STATS), .RX_TDATA(RX_TDATA),
    .RX_TVALID(RX_TVALID), .RX_TLAST(RX_TLAST), .RX_TUSER(RX_TUSER),
    .RX_FILTER_TUSER(RX_FILTER_TUSER), .RX_STATS(RX_STATS), .RX_STATS_VALID(RX_STATS_VALID));
  mss_client client (.clk(CLK), .resetn(RESETN), .tvalid(RX_TVALID), .tlast(RX_TLAST),
    .tuser(RX_TUSER), .n_bytes(nb), .n_frames(nf), .n_bad(nbad));
  // ----
  // checking
  // ----
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("counts: %0d checks, %0d mismatches", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  function automatic logic [31:0] tx_word(int n, int c, mss_tx_outcome_t o);
    logic [31:0] w;
    w = '0;
    w[28:25] = 4'(n - 1);
    w[23] = n == 16 && c == 16;
    w[22] = o.late_coll;
    w[21] = o.defer_long;
    w[20] = o.deferred | o.defer_long;
    w[19] = ven && o.ftype == MSS_TYPE_VLAN;
    w[18:5] = 14'((o.len > MSS_LEN_SAT) ? MSS_LEN_SAT : o.len);
    w[4] = o.ftype == MSS_TYPE_CTRL;
    w[3] = o.underrun;
    w[2] = o.da[0];
    w[1] = o.da == MSS_DA_BCAST;
    w[0] = !(o.late_coll | o.defer_long | o.underrun | w[23]);
    return w;
  endfunction : tx_word
  // outputs are registered, so the falling edge sees them settled
  always @(negedge CLK) begin
    cyc++;
    if (PREADY) begin
      e = apbq.pop_front();
      chk({PSLVERR, e[33] ? PRDATA : e[31:0]}, e[32:0]);
    end
    if (TX_STATS_VALID) chk(TX_STATS, txq.pop_front());
    if (RX_TVALID) chk({RX_TDATA, RX_TLAST, RX_TUSER, RX_FILTER_TUSER}, rxq.pop_front());
    else chk({RX_TLAST, RX_TUSER}, 2'b00);
    chk(RX_STATS_VALID, RX_TVALID & RX_TLAST);
    if (RX_STATS_VALID) chk(RX_STATS, rsq.pop_front());
    if (cyc == 4000) begin
      n_fail++;
      complete_run();
    end
  end
  // ----
  // drivers
  // ----
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    input logic [33:0] x);
    apbq.push_back(x);
    @(posedge CLK);
    PSEL <= 1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1;
    // pready is read at the rising edge itself; only the bench timeout ends a hang
    do begin
      @(posedge CLK);
    end while (!PREADY);
    PSEL <= 0;
    PENABLE <= 0;
  endtask : apb
  task automatic tx_frame(input int n, input int c, input mss_tx_outcome_t o);
    for (int i = 0; i < n; i++) begin
      @(posedge CLK);
      TX_START <= (i == 0);
      TX_ATTEMPT <= 1;
      TX_COLLISION <= 0;
      @(posedge CLK);
      TX_START <= 0;
      TX_ATTEMPT <= 0;
      TX_COLLISION <= (i < c);
    end
    @(posedge CLK);
    TX_COLLISION <= 0;
    TX_END <= 1;
    TX_OUTCOME <= o;
    last_tx = tx_word(n, c, o);
    txq.push_back(last_tx);
    @(posedge CLK);
    TX_END <= 0;
  endtask : tx_frame
  task automatic rx_frame(input int len, input logic err);
    logic [7:0] b;
    logic [3:0] f;
    last_rx = 28'($urandom);
    rsq.push_back(last_rx);
    for (int i = 0; i < len; i++) begin
      b = 8'($urandom);
      f = 4'($urandom);
      @(posedge CLK);
      RX_IN_VALID <= 1;
      RX_IN_DATA <= b;
      RX_IN_LAST <= (i == len - 1);
      RX_IN_ERR <= err && i == len - 1;
      RX_IN_FILT <= f;
      RX_IN_STATS <= last_rx;
      rxq.push_back({b, i == len - 1, err && i == len - 1, f});
    end
    eb += len;
    ef++;
    ebad += int'(err);
    @(posedge CLK);
    RX_IN_VALID <= 0;
    RX_IN_LAST <= 0;
    RX_IN_ERR <= 0;
  endtask : rx_frame
  // ----
  // main sequence
  // ----
  initial begin
    mss_tx_outcome_t o;
    logic [15:0] types [4];
    int n;
    int c;
    types = '{16'h0800, MSS_TYPE_CTRL, MSS_TYPE_VLAN, 16'h88F7};
    void'($urandom(90));
    repeat (5) @(posedge CLK);
    RESETN <= 1;
    apb(0, MSS_REG_CTRL, 0, {2'b10, 32'h0});
    apb(0, MSS_REG_TXSTAT, 0, {2'b10, 32'h0});
    apb(0, 12'h00C, 0, {2'b11, 32'h0});
    $display("test reset_and_map done");
    for (int k = 0; k < 32; k++) begin
      // second half repeats the mix with tagged-frame reporting on
      if (k == 16) begin
        apb(1, MSS_REG_CTRL, 32'h0000_0001, 34'h0);
        apb(1, MSS_REG_TXSTAT, 32'hFFFF_FFFF, 34'h0);
        ven = 1;
      end
      n = (k % 3 == 0) ? 16 : $urandom_range(16, 1);
      c = (k % 2 == 0) ? n : $urandom_range(n - 1);
      o = {4'($urandom), types[k % 4], (k % 5 == 0) ? MSS_DA_BCAST : 48'({$urandom, $urandom}),
        (k % 4 == 0) ? MSS_LEN_SAT + 16'(k / 4 % 2) : 16'($urandom_range(16'h4000))};
      tx_frame(n, c, o);
    end
    apb(0, MSS_REG_CTRL, 0, {2'b10, 32'h0000_0001});
    apb(0, MSS_REG_TXSTAT, 0, {2'b10, last_tx});
    $display("test tx_stats done");
    for (int k = 0; k < 6; k++) rx_frame(1 + k * 3, k[0]);
    apb(0, MSS_REG_RXSTAT, 0, {2'b10, 4'h0, last_rx});
    repeat (3) @(posedge CLK);
    chk(nb, eb);
    chk(nf, ef);
    chk(nbad, ebad);
    chk(txq.size() + rxq.size() + rsq.size() + apbq.size(), 0);
    $display("test rx_stream done");
    RESETN <= 0;
    @(posedge CLK);
    chk({TX_STATS, TX_STATS_VALID, RX_TVALID, RX_STATS_VALID}, 0);
    RESETN <= 1;
    apb(0, MSS_REG_CTRL, 0, {2'b10, 32'h0});
    repeat (3) @(posedge CLK);
    $display("test mid_reset done");
    complete_run();
  end
endmodule : testbench
